//--- verilog/camd_regs.vh
// Constants of the addressing-mode decoder: opcodes, prebytes, mode codes.
// Assumes inclusion by the decoder, its address unit and the port checker.
`ifndef CAMD_REGS_VH
`define CAMD_REGS_VH

// Prebyte opcodes
`define CAMD_PRE_NONE   8'h00
`define CAMD_PRE_SECOND 8'h90
`define CAMD_PRE_IND_Y  8'h91
`define CAMD_PRE_IND    8'h92

// Mask-level instructions
`define CAMD_OPC_MASK_RAISE 8'h9B
`define CAMD_OPC_MASK_CLEAR 8'h9A
`define CAMD_IMASK_HIGH     2'h3
`define CAMD_IMASK_LOW      2'h0
`define CAMD_IMASK_RESET    2'h3

// Opcode row codes (upper nibble)
`define CAMD_ROW_BTJ    4'h0
`define CAMD_ROW_BIT    4'h1
`define CAMD_ROW_REL    4'h2
`define CAMD_ROW_RMW_D  4'h3
`define CAMD_ROW_RMW_X  4'h6
`define CAMD_ROW_RMW_X0 4'h7
`define CAMD_ROW_IMM    4'hA
`define CAMD_ROW_DIR_S  4'hB
`define CAMD_ROW_DIR_L  4'hC
`define CAMD_ROW_IX_L   4'hD
`define CAMD_ROW_IX_S   4'hE
`define CAMD_ROW_IX0    4'hF

// Addressing variants, 17 plus illegal
`define CAMD_M_INH   5'h00
`define CAMD_M_IMM   5'h01
`define CAMD_M_DIR_S 5'h02
`define CAMD_M_DIR_L 5'h03
`define CAMD_M_IX0   5'h04
`define CAMD_M_IX_S  5'h05
`define CAMD_M_IX_L  5'h06
`define CAMD_M_IND_S 5'h07
`define CAMD_M_IND_L 5'h08
`define CAMD_M_IIX_S 5'h09
`define CAMD_M_IIX_L 5'h0A
`define CAMD_M_REL   5'h0B
`define CAMD_M_REL_I 5'h0C
`define CAMD_M_BIT   5'h0D
`define CAMD_M_BIT_I 5'h0E
`define CAMD_M_BTR   5'h0F
`define CAMD_M_BTR_I 5'h10
`define CAMD_M_ILL   5'h11

// Page zero upper byte
`define CAMD_PAGE0 8'h00

`endif

//--- verilog/camd_ea_calc.v
// Effective address and branch target from the fetched instruction bytes.
// Assumes stable inputs from the decoder's registers; purely combinational.
`include "camd_regs.vh"

module camd_ea_calc (
    input  wire [4:0]  mode_i,
    input  wire [7:0]  idx_i,
    input  wire [15:0] arg_i,
    input  wire [15:0] ptr_i,
    input  wire [15:0] pc_end_i,
    output reg  [15:0] ea_o,
    output reg  [15:0] target_o
);

    wire [15:0] idx_w;
    reg  [7:0]  off;

    assign idx_w = {`CAMD_PAGE0, idx_i};

    // Signed relative offset selection and target
    always @* begin
        case (mode_i)
            `CAMD_M_REL_I: off = ptr_i[7:0];
            default:       off = arg_i[7:0];
        endcase
        target_o = pc_end_i + {{8{off[7]}}, off};
    end

    // Operand address per mode
    always @* begin
        case (mode_i)
            `CAMD_M_IMM:   ea_o = pc_end_i - 16'h0001;
            `CAMD_M_DIR_S: ea_o = {`CAMD_PAGE0, arg_i[7:0]};
            `CAMD_M_DIR_L: ea_o = arg_i;
            `CAMD_M_IX0:   ea_o = idx_w;
            `CAMD_M_IX_S:  ea_o = idx_w + {`CAMD_PAGE0, arg_i[7:0]};
            `CAMD_M_IX_L:  ea_o = idx_w + arg_i;
            `CAMD_M_IND_S: ea_o = {`CAMD_PAGE0, ptr_i[7:0]};
            `CAMD_M_IND_L: ea_o = ptr_i;
            `CAMD_M_IIX_S: ea_o = idx_w + {`CAMD_PAGE0, ptr_i[7:0]};
            `CAMD_M_IIX_L: ea_o = idx_w + ptr_i;
            `CAMD_M_BIT:   ea_o = {`CAMD_PAGE0, arg_i[7:0]};
            `CAMD_M_BTR:   ea_o = {`CAMD_PAGE0, arg_i[15:8]};
            `CAMD_M_BIT_I: ea_o = {`CAMD_PAGE0, ptr_i[7:0]};
            `CAMD_M_BTR_I: ea_o = {`CAMD_PAGE0, ptr_i[7:0]};
            `CAMD_M_REL:   ea_o = target_o;
            `CAMD_M_REL_I: ea_o = target_o;
            default:       ea_o = 16'h0000;
        endcase
    end

endmodule // camd_ea_calc

//--- verilog/camd_decoder.v
// Addressing-mode decoder: fetches prebyte, opcode, operand and pointer
// bytes over the memory read port and reports address, length and target.
// Assumes a memory port that answers each read with a one-cycle ack.
`include "camd_regs.vh"

// Function
// - Seventeen addressing variants in seven groups.
// - Inherent instruction is one opcode byte.
// - Immediate is opcode plus operand byte.
// - Short non-indexed forms reach page zero only.
// - Long forms reach full 64K space.
// - Read-modify-write instructions take short forms only.
// - Short direct: one address byte follows.
// - Long direct: two address bytes follow.
// - Indexed address is index plus offset.
// - No-offset indexed: index alone is address.
// - Short indexed: byte offset, up to 1FE.
// - Long indexed: word offset, full space.
// - Indirect: pointer address follows, read pointer.
// - Short indirect: byte pointer, page zero.
// - Long indirect forms: word pointer, full space.
// - Indirect indexed: index plus fetched pointer.
// - Short indirect indexed spans up to 1FE.
// - Mask-raise instruction sets mask level three.
// - Mask-clear instruction sets mask level zero.
// - Relative adds signed byte to program counter.
// - Three prebytes select second register or indirect.
module camd_decoder (
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire        start_i,
    input  wire [15:0] program_counter_i,
    input  wire [7:0]  idx_first_i,
    input  wire [7:0]  idx_second_i,
    output wire        mem_rd_o,
    output reg  [15:0] mem_addr_o,
    input  wire        mem_ack_i,
    input  wire [7:0]  mem_rdata_i,
    output wire        busy_o,
    output reg         done_o,
    output reg         illegal_o,
    output reg  [4:0]  mode_o,
    output reg  [7:0]  opcode_o,
    output reg  [7:0]  prebyte_o,
    output reg         use_second_o,
    output reg  [2:0]  length_o,
    output reg  [15:0] ea_o,
    output reg  [15:0] target_o,
    output reg  [15:0] next_pc_o,
    output reg  [1:0]  imask_o
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_OPC  = 3'h1;
    localparam [2:0] S_ARG  = 3'h2;
    localparam [2:0] S_PTR  = 3'h3;
    localparam [2:0] S_DONE = 3'h4;

    reg  [2:0]  state_q;
    reg  [7:0]  pre_q;
    reg  [7:0]  opc_q;
    reg  [4:0]  mode_q;
    reg  [1:0]  cnt_q;
    reg  [15:0] arg_q;
    reg  [15:0] ptr_q;
    reg  [15:0] pc_q;
    reg  [15:0] start_pc_q;
    reg  [7:0]  x_q;
    reg  [7:0]  y_q;
    wire [4:0]  dec_mode;
    wire [15:0] calc_ea;
    wire [15:0] calc_target;
    wire [7:0]  idx_sel;
    wire        sel_second;
    wire [15:0] arg_next;
    wire [7:0]  ptr_addr;
    wire [15:0] len_w;

    // Prebyte recognition
    function is_prebyte;
        input [7:0] b;
        begin
            is_prebyte = (b == `CAMD_PRE_SECOND) || (b == `CAMD_PRE_IND_Y)
                      || (b == `CAMD_PRE_IND);
        end
    endfunction

    // Mode from prebyte and opcode row
    function [4:0] decode_mode;
        input [7:0] pre;
        input [7:0] opc;
        reg         ind;
        reg         ind_y;
        begin
            ind   = (pre == `CAMD_PRE_IND);
            ind_y = (pre == `CAMD_PRE_IND_Y);
            decode_mode = `CAMD_M_ILL;
            case (opc[7:4])
                `CAMD_ROW_BTJ:   decode_mode = ind ? `CAMD_M_BTR_I : `CAMD_M_BTR;
                `CAMD_ROW_BIT:   decode_mode = ind ? `CAMD_M_BIT_I : `CAMD_M_BIT;
                `CAMD_ROW_REL:   decode_mode = ind ? `CAMD_M_REL_I : `CAMD_M_REL;
                // Read-modify-write rows have no long form
                `CAMD_ROW_RMW_D: decode_mode = ind ? `CAMD_M_IND_S : `CAMD_M_DIR_S;
                `CAMD_ROW_RMW_X: decode_mode = (ind || ind_y) ? `CAMD_M_IIX_S
                                                              : `CAMD_M_IX_S;
                `CAMD_ROW_RMW_X0: decode_mode = `CAMD_M_IX0;
                `CAMD_ROW_IMM:   decode_mode = `CAMD_M_IMM;
                `CAMD_ROW_DIR_S: decode_mode = ind ? `CAMD_M_IND_S : `CAMD_M_DIR_S;
                `CAMD_ROW_DIR_L: decode_mode = ind ? `CAMD_M_IND_L : `CAMD_M_DIR_L;
                `CAMD_ROW_IX_L:  decode_mode = (ind || ind_y) ? `CAMD_M_IIX_L
                                                              : `CAMD_M_IX_L;
                `CAMD_ROW_IX_S:  decode_mode = (ind || ind_y) ? `CAMD_M_IIX_S
                                                              : `CAMD_M_IX_S;
                `CAMD_ROW_IX0:   decode_mode = `CAMD_M_IX0;
                default:         decode_mode = `CAMD_M_INH;
            endcase
            // Prebyte legality
            if (ind_y && !((opc[7:4] == `CAMD_ROW_RMW_X) || (opc[7:4] == `CAMD_ROW_IX_L)
                || (opc[7:4] == `CAMD_ROW_IX_S))) begin
                decode_mode = `CAMD_M_ILL;
            end
            if (ind && ((decode_mode == `CAMD_M_INH) || (decode_mode == `CAMD_M_IMM)
                || (decode_mode == `CAMD_M_IX0))) begin
                decode_mode = `CAMD_M_ILL;
            end
        end
    endfunction

    // Operand bytes after the opcode
    function [1:0] arg_count;
        input [4:0] m;
        begin
            case (m)
                `CAMD_M_INH:   arg_count = 2'd0;
                `CAMD_M_IX0:   arg_count = 2'd0;
                `CAMD_M_ILL:   arg_count = 2'd0;
                `CAMD_M_DIR_L: arg_count = 2'd2;
                `CAMD_M_IX_L:  arg_count = 2'd2;
                `CAMD_M_BTR:   arg_count = 2'd2;
                `CAMD_M_BTR_I: arg_count = 2'd2;
                default:       arg_count = 2'd1;
            endcase
        end
    endfunction

    // Pointer bytes read from memory
    function [1:0] ptr_count;
        input [4:0] m;
        begin
            case (m)
                `CAMD_M_IND_S: ptr_count = 2'd1;
                `CAMD_M_IIX_S: ptr_count = 2'd1;
                `CAMD_M_REL_I: ptr_count = 2'd1;
                `CAMD_M_BIT_I: ptr_count = 2'd1;
                `CAMD_M_BTR_I: ptr_count = 2'd1;
                `CAMD_M_IND_L: ptr_count = 2'd2;
                `CAMD_M_IIX_L: ptr_count = 2'd2;
                default:       ptr_count = 2'd0;
            endcase
        end
    endfunction

    assign dec_mode   = decode_mode(pre_q, mem_rdata_i);
    assign arg_next   = {arg_q[7:0], mem_rdata_i};
    // Bit-test indirect carries its pointer address in the first byte
    assign ptr_addr   = (arg_count(mode_q) == 2'd2) ? arg_q[7:0] : mem_rdata_i;
    assign sel_second = (pre_q == `CAMD_PRE_SECOND) || (pre_q == `CAMD_PRE_IND_Y);
    assign idx_sel    = sel_second ? y_q : x_q;
    assign len_w      = pc_q - start_pc_q;

    // Handshake outputs
    assign mem_rd_o = (state_q == S_OPC) || (state_q == S_ARG) || (state_q == S_PTR);
    assign busy_o   = (state_q != S_IDLE);

    camd_ea_calc u_calc (
        .mode_i   (mode_q),
        .idx_i    (idx_sel),
        .arg_i    (arg_q),
        .ptr_i    (ptr_q),
        .pc_end_i (pc_q),
        .ea_o     (calc_ea),
        .target_o (calc_target)
    );

    // Fetch sequencer
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q    <= S_IDLE;
            pre_q      <= `CAMD_PRE_NONE;
            opc_q      <= 8'h00;
            mode_q     <= `CAMD_M_INH;
            cnt_q      <= 2'd0;
            arg_q      <= 16'h0000;
            ptr_q      <= 16'h0000;
            pc_q       <= 16'h0000;
            start_pc_q <= 16'h0000;
            x_q        <= 8'h00;
            y_q        <= 8'h00;
            mem_addr_o <= 16'h0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_i) begin
                        pc_q       <= program_counter_i;
                        start_pc_q <= program_counter_i;
                        mem_addr_o <= program_counter_i;
                        x_q        <= idx_first_i;
                        y_q        <= idx_second_i;
                        pre_q      <= `CAMD_PRE_NONE;
                        arg_q      <= 16'h0000;
                        ptr_q      <= 16'h0000;
                        state_q    <= S_OPC;
                    end
                end
                S_OPC: begin
                    if (mem_ack_i) begin
                        pc_q       <= pc_q + 16'h0001;
                        mem_addr_o <= pc_q + 16'h0001;
                        cnt_q      <= 2'd0;
                        // Only one prebyte per instruction
                        if (is_prebyte(mem_rdata_i) && (pre_q == `CAMD_PRE_NONE)) begin
                            pre_q <= mem_rdata_i;
                        end else begin
                            opc_q  <= mem_rdata_i;
                            mode_q <= dec_mode;
                            if (arg_count(dec_mode) == 2'd0) begin
                                state_q <= S_DONE;
                            end else begin
                                state_q <= S_ARG;
                            end
                        end
                    end
                end
                S_ARG: begin
                    if (mem_ack_i) begin
                        arg_q <= arg_next;
                        pc_q  <= pc_q + 16'h0001;
                        cnt_q <= cnt_q + 2'd1;
                        if (cnt_q == arg_count(mode_q) - 2'd1) begin
                            cnt_q <= 2'd0;
                            if (ptr_count(mode_q) != 2'd0) begin
                                mem_addr_o <= {`CAMD_PAGE0, ptr_addr};
                                state_q    <= S_PTR;
                            end else begin
                                state_q <= S_DONE;
                            end
                        end else begin
                            mem_addr_o <= pc_q + 16'h0001;
                        end
                    end
                end
                S_PTR: begin
                    if (mem_ack_i) begin
                        ptr_q      <= {ptr_q[7:0], mem_rdata_i};
                        mem_addr_o <= mem_addr_o + 16'h0001;
                        cnt_q      <= cnt_q + 2'd1;
                        if (cnt_q == ptr_count(mode_q) - 2'd1) begin
                            state_q <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Result registers and completion pulse
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_o       <= 1'b0;
            illegal_o    <= 1'b0;
            mode_o       <= `CAMD_M_INH;
            opcode_o     <= 8'h00;
            prebyte_o    <= `CAMD_PRE_NONE;
            use_second_o <= 1'b0;
            length_o     <= 3'd0;
            ea_o         <= 16'h0000;
            target_o     <= 16'h0000;
            next_pc_o    <= 16'h0000;
        end else begin
            done_o <= (state_q == S_DONE);
            if (state_q == S_DONE) begin
                illegal_o    <= (mode_q == `CAMD_M_ILL);
                mode_o       <= mode_q;
                opcode_o     <= opc_q;
                prebyte_o    <= pre_q;
                use_second_o <= sel_second;
                length_o     <= len_w[2:0];
                ea_o         <= calc_ea;
                target_o     <= calc_target;
                next_pc_o    <= pc_q;
            end
        end
    end

    // Interrupt mask level from inherent mask instructions
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            imask_o <= `CAMD_IMASK_RESET;
        end else if ((state_q == S_DONE) && (mode_q == `CAMD_M_INH)
                     && (pre_q == `CAMD_PRE_NONE)) begin
            if (opc_q == `CAMD_OPC_MASK_RAISE) begin
                imask_o <= `CAMD_IMASK_HIGH;
            end else if (opc_q == `CAMD_OPC_MASK_CLEAR) begin
                imask_o <= `CAMD_IMASK_LOW;
            end
        end
    end

endmodule // camd_decoder

//--- bench/camd_mem_model.sv
// Byte memory on the decoder's read port, with a settable wait.
// Assumes one read at a time, held until acknowledged.
module camd_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [3:0]  wait_n_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    output logic             mem_ack_o,
    output logic [7:0]       mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic [3:0] cnt_q;
    // Ack once the wait is used up
    assign mem_ack_o = mem_rd_i && (cnt_q >= wait_n_i);
    // Data valid only with ack, else the inverse of the last byte
    assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i] : ~last_q;
    // Wait counter and last byte
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 4'h0;
            last_q <= 8'h00;
        end else if (mem_ack_o) begin
            cnt_q <= 4'h0;
            last_q <= mem_rdata_o;
        end else if (mem_rd_i) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // Background pattern
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
    end
endmodule // camd_mem_model

//--- bench/camd_decoder_monitor.sv
// Port checker of the addressing-mode decoder.
// Assumes binding to camd_decoder; one clock domain.
`include "camd_regs.vh"
module camd_decoder_monitor (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        start_i,
    input  wire logic [15:0] program_counter_i,
    input  wire logic        mem_rd_o,
    input  wire logic [15:0] mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic        busy_o,
    input  wire logic        done_o,
    input  wire logic        illegal_o,
    input  wire logic [4:0]  mode_o,
    input  wire logic [7:0]  opcode_o,
    input  wire logic [7:0]  prebyte_o,
    input  wire logic [2:0]  length_o,
    input  wire logic [15:0] ea_o,
    input  wire logic [15:0] target_o,
    input  wire logic [15:0] next_pc_o,
    input  wire logic [1:0]  imask_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pc_q;
    // Start address of the instruction under way
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) pc_q <= 16'h0000;
        else if (start_i && !busy_o) pc_q <= program_counter_i;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_first_fetch: assert property (start_i && !busy_o |=> mem_rd_o
        && mem_addr_o == $past(program_counter_i))
        else $error("first read not at start address");
    a_addr_held: assert property (mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
        else $error("read dropped before ack");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_done_bound: assert property (start_i && !busy_o |-> ##[3:60] done_o)
        else $error("no done after start");
    a_next_pc: assert property (done_o && !illegal_o |-> next_pc_o == pc_q + {13'h0000, length_o})
        else $error("next address not start plus length");
    a_ill_code: assert property (done_o |-> illegal_o == (mode_o == `CAMD_M_ILL))
        else $error("illegal flag and mode disagree");
    a_page_zero: assert property (done_o && (mode_o == `CAMD_M_DIR_S || mode_o == `CAMD_M_IX0
        || mode_o == `CAMD_M_IND_S || mode_o == `CAMD_M_BIT) |-> ea_o[15:8] == 8'h00)
        else $error("short address outside page zero");
    a_short_span: assert property (done_o && (mode_o == `CAMD_M_IX_S || mode_o == `CAMD_M_IIX_S)
        |-> ea_o <= 16'h01FE)
        else $error("short indexed beyond 1FE");
    a_rel_target: assert property (done_o && (mode_o == `CAMD_M_REL || mode_o == `CAMD_M_REL_I)
        |-> ea_o == target_o)
        else $error("relative address differs from target");
    a_imm_addr: assert property (done_o && mode_o == `CAMD_M_IMM |-> ea_o == next_pc_o - 16'h0001)
        else $error("immediate operand not last byte");
    a_mask_raise: assert property (done_o && opcode_o == `CAMD_OPC_MASK_RAISE
        && prebyte_o == `CAMD_PRE_NONE |-> imask_o == `CAMD_IMASK_HIGH)
        else $error("mask not raised");
    a_mask_clear: assert property (done_o && opcode_o == `CAMD_OPC_MASK_CLEAR
        && prebyte_o == `CAMD_PRE_NONE |-> imask_o == `CAMD_IMASK_LOW)
        else $error("mask not cleared");
endmodule // camd_decoder_monitor

bind camd_decoder camd_decoder_monitor i_camd_decoder_monitor (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .start_i(start_i), .program_counter_i(program_counter_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .mode_o(mode_o),
    .opcode_o(opcode_o), .prebyte_o(prebyte_o), .length_o(length_o), .ea_o(ea_o), .target_o(target_o),
    .next_pc_o(next_pc_o), .imask_o(imask_o));

//--- bench/camd_decoder_tb.sv
// Self-checking bench of the addressing-mode decoder.
// Assumes camd_mem_model on the read port; instruction placed at 0100.
module camd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PC = 16'h0100;
    logic sys_clk_i, arst_n_i, start_i, mem_rd_o, mem_ack_i, busy_o, done_o, illegal_o, use_second_o;
    logic [15:0] mem_addr_o, ea_o, target_o, next_pc_o;
    logic [7:0]  mem_rdata_o, opcode_o, prebyte_o;
    logic [4:0]  mode_o;
    logic [2:0]  length_o;
    logic [1:0]  imask_o;
    logic [3:0]  wait_n;
    int          err_total, cmp_count;

    camd_decoder i_camd_decoder (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .start_i(start_i),
        .program_counter_i(PC), .idx_first_i(8'h80), .idx_second_i(8'hC5), .mem_rd_o(mem_rd_o),
        .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_o), .busy_o(busy_o),
        .done_o(done_o), .illegal_o(illegal_o), .mode_o(mode_o), .opcode_o(opcode_o), .prebyte_o(prebyte_o),
        .use_second_o(use_second_o), .length_o(length_o), .ea_o(ea_o), .target_o(target_o),
        .next_pc_o(next_pc_o), .imask_o(imask_o));
    camd_mem_model i_camd_mem_model (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wait_n_i(wait_n),
        .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_o));

    // 40 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic poke(input logic [15:0] a, input logic [7:0] d);
        i_camd_mem_model.mem[a] = d;
    endtask

    // Decode one instruction; fl: 0 address, 1 target, 2 length
    task automatic run(input logic [31:0] code, input logic [4:0] em, input logic [2:0] el,
                       input logic [15:0] eea, input logic [15:0] etg, input logic [2:0] fl);
        int n;
        for (n = 0; n < 4; n++) poke(PC + 16'(n), code[31 - 8 * n -: 8]);
        @(posedge sys_clk_i);
        start_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        start_i <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 100);
        // Limit used up without a completion pulse
        if (done_o !== 1'b1) begin
            cmp({15'h0000, done_o}, 16'h0001);
            report_and_stop();
        end
        cmp({11'h000, mode_o}, {11'h000, em});
        if (fl[2]) cmp({13'h0000, length_o}, {13'h0000, el});
        if (fl[2]) cmp(next_pc_o, PC + {13'h0000, el});
        if (fl[0]) cmp(ea_o, eea);
        if (fl[1]) cmp(target_o, etg);
    endtask

    task automatic t_direct_indexed();
        run(32'h9D000000, 5'h00, 3'd1, 16'h0000, 16'h0000, 3'b100);
        run(32'hA6550000, 5'h01, 3'd2, 16'h0101, 16'h0000, 3'b101);
        run(32'hB6100000, 5'h02, 3'd2, 16'h0010, 16'h0000, 3'b101);
        run(32'hC6123400, 5'h03, 3'd3, 16'h1234, 16'h0000, 3'b101);
        run(32'hF6000000, 5'h04, 3'd1, 16'h0080, 16'h0000, 3'b101);
        run(32'hE6FF0000, 5'h05, 3'd2, 16'h017F, 16'h0000, 3'b101);
        run(32'hD6FFF000, 5'h06, 3'd3, 16'h0070, 16'h0000, 3'b101);
        run(32'h90F60000, 5'h04, 3'd2, 16'h00C5, 16'h0000, 3'b101);
        cmp({15'h0000, use_second_o}, 16'h0001);
        cmp({8'h00, prebyte_o}, 16'h0090);
        cmp({8'h00, opcode_o}, 16'h00F6);
    endtask

    task automatic t_indirect();
        poke(16'h0010, 8'h44);
        poke(16'h0020, 8'h12);
        poke(16'h0021, 8'h34);
        poke(16'h0030, 8'hF0);
        poke(16'h0040, 8'hFF);
        poke(16'h0041, 8'h80);
        run(32'h92B61000, 5'h07, 3'd3, 16'h0044, 16'h0000, 3'b101);
        run(32'h92C62000, 5'h08, 3'd3, 16'h1234, 16'h0000, 3'b101);
        run(32'h92E63000, 5'h09, 3'd3, 16'h0170, 16'h0000, 3'b101);
        run(32'h91D64000, 5'h0A, 3'd3, 16'h0045, 16'h0000, 3'b101);
        cmp({15'h0000, use_second_o}, 16'h0001);
    endtask

    task automatic t_rel_bit();
        poke(16'h0050, 8'h10);
        poke(16'h0070, 8'h77);
        run(32'h20FE0000, 5'h0B, 3'd2, 16'h0100, 16'h0100, 3'b111);
        run(32'h92205000, 5'h0C, 3'd3, 16'h0113, 16'h0113, 3'b111);
        run(32'h10600000, 5'h0D, 3'd2, 16'h0060, 16'h0000, 3'b101);
        run(32'h92107000, 5'h0E, 3'd3, 16'h0077, 16'h0000, 3'b101);
        run(32'h00600500, 5'h0F, 3'd3, 16'h0060, 16'h0108, 3'b111);
        run(32'h92007080, 5'h10, 3'd4, 16'h0077, 16'h0084, 3'b111);
    endtask

    task automatic t_rmw_mask_ill();
        run(32'h3C100000, 5'h02, 3'd2, 16'h0010, 16'h0000, 3'b101);
        run(32'h6CF00000, 5'h05, 3'd2, 16'h0170, 16'h0000, 3'b101);
        run(32'h7C000000, 5'h04, 3'd1, 16'h0080, 16'h0000, 3'b101);
        run(32'h9A000000, 5'h00, 3'd1, 16'h0000, 16'h0000, 3'b100);
        cmp({14'h0000, imask_o}, 16'h0000);
        run(32'h9B000000, 5'h00, 3'd1, 16'h0000, 16'h0000, 3'b100);
        cmp({14'h0000, imask_o}, 16'h0003);
        run(32'h92A60000, 5'h11, 3'd0, 16'h0000, 16'h0000, 3'b000);
        cmp({15'h0000, illegal_o}, 16'h0001);
        run(32'h91B61000, 5'h11, 3'd0, 16'h0000, 16'h0000, 3'b000);
        cmp({15'h0000, illegal_o}, 16'h0001);
    endtask

    // Main sequence, first with immediate answers, then with waits
    initial begin
        err_total = 0;
        cmp_count = 0;
        arst_n_i = 1'b0;
        start_i = 1'b0;
        wait_n = 4'h0;
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        #1;
        cmp({14'h0000, imask_o}, 16'h0003);
        cmp({15'h0000, done_o}, 16'h0000);
        t_direct_indexed();
        t_indirect();
        t_rel_bit();
        t_rmw_mask_ill();
        wait_n = 4'h3;
        t_indirect();
        t_rel_bit();
        report_and_stop();
    end
endmodule // camd_decoder_tb
